//--- core_model.sv
// core model: boot-loader code issuing one-cycle store requests
// assumes the bench raises go for one cycle per request
`timescale 1ns/10ps
module core_model
   import self_prog_pkg::*;
(
   // clock and bench command
   input  wire logic        aclk,
   input  wire logic        go,
   input  wire spm_op_e     op,
   input  wire logic [12:0] pc,
   input  wire logic [12:0] addr,
   // store request to the block
   output spm_op_e          spm_op = SPM_LOAD,
   output logic             spm_valid = 1'b0,
   output logic [12:0]      spm_pc = 13'h0000,
   output logic [12:0]      spm_addr = 13'h0000
);
   // -------------------------------------------------------------
   // request launch
   // -------------------------------------------------------------
   // idle pc and addr lines toggle, so stray samples never repeat a request
   always @(posedge aclk) begin
      spm_valid <= go;
      spm_op    <= op;
      spm_pc    <= go ? pc : ~spm_pc;
      spm_addr  <= go ? addr : ~spm_addr;
   end
endmodule : core_model

//--- prog_timer.sv
// down-counter that times one flash erase, write or lock write
// assumes start is a one-cycle pulse from logic on the same clock
`timescale 1ns/10ps
module prog_timer
   import self_prog_pkg::*;
#(
   parameter int CNT_W = PROG_CNT_W
) (
   // clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // control
   input  wire logic             start,
   input  wire logic [CNT_W-1:0] cycles,
   // status
   output logic                  running,
   output logic                  done
);

   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic             running;
      logic             done;
   } timer_s;

   timer_s st;
   timer_s next_st;

   // ------------------------------------------------------------------
   // count down, done pulses in the first cycle after the interval, as running falls
   // ------------------------------------------------------------------
   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      if (start) begin
         next_st.count   = cycles;
         next_st.running = 1'b1;
      end else if (st.running) begin
         if (st.count <= CNT_W'(1)) begin
            next_st.running = 1'b0;
            next_st.done    = 1'b1;
            next_st.count   = '0;
         end else begin
            next_st.count = st.count - CNT_W'(1);
         end
      end
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign running = st.running;
   assign done    = st.done;

endmodule : prog_timer

//--- self_prog_pkg.sv
// constants, types and register map of the self-programming section control
// assumes a single 200 MHz core clock and word-addressed program flash
package self_prog_pkg;

   // ------------------------------------------------------------------
   // clock and programming time
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS     = 5;
   localparam int PROG_TIME_MIN_NS  = 3700000;  // 3.7 ms
   localparam int PROG_TIME_MAX_NS  = 4500000;  // 4.5 ms
   localparam int PROG_CYCLES_MIN   = (PROG_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PROG_CYCLES_MAX   = PROG_TIME_MAX_NS / CLK_PERIOD_NS;
   localparam int PROG_CNT_W        = 20;       // holds PROG_CYCLES_MAX

   // ------------------------------------------------------------------
   // register map (byte offsets on the register bus)
   // ------------------------------------------------------------------
   localparam int REG_ADDR_W        = 4;
   localparam logic [1:0] CTRL_IDX   = 2'h0;    // byte 0x0
   localparam logic [1:0] STATUS_IDX = 2'h1;    // byte 0x4
   localparam logic [1:0] LOCK_IDX   = 2'h2;    // byte 0x8
   localparam logic [1:0] BOUND_IDX  = 2'h3;    // byte 0xC

   // control fields (write-one strobes)
   localparam int CTRL_READ_EN_BIT  = 0;

   // status fields
   localparam int ST_OP_BUSY_BIT    = 0;
   localparam int ST_CONC_BUSY_BIT  = 1;
   localparam int ST_STALL_BIT      = 2;
   localparam int ST_IGNORED_BIT    = 3;       // sticky, write one to clear
   localparam int ST_DENIED_BIT     = 4;       // sticky, write one to clear

   // lock fields: group 0 governs application area, group 1 boot area
   localparam int LOCK_G0_LSB       = 0;
   localparam int LOCK_G1_LSB       = 2;
   localparam logic [3:0] LOCK_RESET = 4'hF;    // all unprogrammed

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------------
   // store-to-program-memory operations issued by the core
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      SPM_LOAD,
      SPM_ERASE,
      SPM_WRITE,
      SPM_LOCK
   } spm_op_e;

endpackage : self_prog_pkg

//--- self_prog_section_control.sv
// self-programming section control: gates the core's store-to-program-memory
// requests, times erase/write, stalls the core and tracks the busy flag.
// assumes spm requests come from the core on aclk and the fuses are static.
`timescale 1ns/10ps
module self_prog_section_control
   import self_prog_pkg::*;
#(
   parameter int ADDR_W         = 13,
   parameter int HALT_START     = 7168,
   parameter int BOOT_MIN_WORDS = 128,
   parameter int PROG_CYCLES    = PROG_CYCLES_MIN
) (
   // clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // configuration fuses
   input  wire logic [1:0]            boot_size_fuses,
   // store requests from the core
   input  wire logic                  spm_valid,
   input  wire spm_op_e               spm_op,
   input  wire logic [ADDR_W-1:0]     spm_pc,
   input  wire logic [ADDR_W-1:0]     spm_addr,
   input  wire logic [3:0]            spm_lock_data,
   // towards the core and the flash array
   output logic                       core_stall,
   output logic                       concurrent_section_busy,
   output logic                       flash_cmd_valid,
   output spm_op_e                    flash_cmd_op,
   output logic [ADDR_W-1:0]          flash_cmd_addr,
   output logic                       flash_op_done,
   output logic                       spm_ignored,
   // axi4-lite write address
   input  wire logic [REG_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // axi4-lite read address
   input  wire logic [REG_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   // axi4-lite read data
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready
);

   // ------------------------------------------------------------------
   // types and state
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      IDLE,
      PROG
   } state_e;

   typedef struct packed {
      state_e                  state;
      logic                    fuse_taken;
      logic [ADDR_W-1:0]       boot_start;
      logic [3:0]              lock;
      logic                    target_conc;
      logic                    stall;
      logic                    conc_busy;
      logic                    ignored_flag;
      logic                    denied_flag;
      logic                    cmd_valid;
      spm_op_e                 cmd_op;
      logic [ADDR_W-1:0]       cmd_addr;
      logic                    op_done;
      logic                    ignored_pulse;
      logic                    aw_have;
      logic [1:0]              aw_idx;
      logic                    w_have;
      logic [31:0]             w_data;
      logic                    w_byte0;
      logic                    awready;
      logic                    wready;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    arready;
      logic                    rvalid;
      logic [31:0]             rdata;
      logic [1:0]              rresp;
   } ctrl_s;

   localparam int CNT_W = PROG_CNT_W;
   localparam logic [ADDR_W-1:0] HALT_BASE = ADDR_W'(HALT_START);

   ctrl_s            st;
   ctrl_s            next_st;
   logic             timer_start;
   logic             timer_running;
   logic             timer_done;
   logic [ADDR_W:0]  boot_words;
   logic [ADDR_W:0]  boot_start_raw;
   logic [ADDR_W-1:0] boot_start_fix;
   logic             pc_in_boot;
   logic             tgt_in_boot;
   logic             write_locked;
   logic             do_write;
   logic             read_en_strobe;
   logic             status_clear_ign;
   logic             status_clear_den;

   // ------------------------------------------------------------------
   // operation timer
   // ------------------------------------------------------------------
   prog_timer #(
      .CNT_W (CNT_W)
   ) u_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (timer_start),
      .cycles  (CNT_W'(PROG_CYCLES)),
      .running (timer_running),
      .done    (timer_done)
   );

   // ------------------------------------------------------------------
   // boot-area boundary from the fuses
   // ------------------------------------------------------------------
   // programmed fuse bits read zero and give the larger boot area
   always_comb begin
      boot_words     = (ADDR_W+1)'(BOOT_MIN_WORDS) << (~boot_size_fuses);
      boot_start_raw = ((ADDR_W+1)'(1) << ADDR_W) - boot_words;
      // never let the boot area reach below the halting boundary
      if (boot_start_raw < (ADDR_W+1)'(HALT_START)) begin
         boot_start_fix = HALT_BASE;
      end else begin
         boot_start_fix = boot_start_raw[ADDR_W-1:0];
      end
   end

   // ------------------------------------------------------------------
   // request qualification
   // ------------------------------------------------------------------
   always_comb begin
      pc_in_boot  = (spm_pc >= st.boot_start);
      tgt_in_boot = (spm_addr >= st.boot_start);
      // group mode 2 and 3 (low bit programmed) forbid writing the area
      if (tgt_in_boot) begin
         write_locked = !st.lock[LOCK_G1_LSB];
      end else begin
         write_locked = !st.lock[LOCK_G0_LSB];
      end
   end

   // ------------------------------------------------------------------
   // register-bus write decode
   // ------------------------------------------------------------------
   always_comb begin
      do_write         = st.aw_have && st.w_have && !st.bvalid;
      read_en_strobe   = do_write && st.w_byte0 && (st.aw_idx == CTRL_IDX)
                         && st.w_data[CTRL_READ_EN_BIT];
      status_clear_ign = do_write && st.w_byte0 && (st.aw_idx == STATUS_IDX)
                         && st.w_data[ST_IGNORED_BIT];
      status_clear_den = do_write && st.w_byte0 && (st.aw_idx == STATUS_IDX)
                         && st.w_data[ST_DENIED_BIT];
   end

   // ------------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------------
   always_comb begin
      next_st               = st;
      next_st.cmd_valid     = 1'b0;
      next_st.op_done       = 1'b0;
      next_st.ignored_pulse = 1'b0;
      timer_start           = 1'b0;

      // fuses are caught once, on the first edge after reset release
      if (!st.fuse_taken) begin
         next_st.boot_start = boot_start_fix;
         next_st.fuse_taken = 1'b1;
      end

      // sticky flags: clears first so a same-cycle event wins
      if (status_clear_ign) begin
         next_st.ignored_flag = 1'b0;
      end
      if (status_clear_den) begin
         next_st.denied_flag = 1'b0;
      end
      // re-enable only after the operation has finished
      if (read_en_strobe && st.state == IDLE) begin
         next_st.conc_busy = 1'b0;
      end

      case (st.state)
         IDLE: begin
            if (spm_valid && st.fuse_taken) begin
               if (!pc_in_boot) begin
                  next_st.ignored_flag  = 1'b1;
                  next_st.ignored_pulse = 1'b1;
               end else if (spm_op == SPM_LOAD) begin
                  next_st.conc_busy = 1'b0;
                  next_st.cmd_valid = 1'b1;
                  next_st.cmd_op    = spm_op;
                  next_st.cmd_addr  = spm_addr;
               end else if (spm_op == SPM_LOCK) begin
                  // lock bits can only be programmed (driven to zero) here
                  next_st.lock      = st.lock & spm_lock_data;
                  next_st.cmd_valid = 1'b1;
                  next_st.cmd_op    = spm_op;
                  next_st.cmd_addr  = spm_addr;
                  next_st.stall     = 1'b1;
                  next_st.state     = PROG;
                  timer_start       = 1'b1;
               end else if (write_locked) begin
                  next_st.denied_flag = 1'b1;
               end else begin
                  // the fetch area plays no part in the stall decision
                  next_st.target_conc = (spm_addr < HALT_BASE);
                  next_st.stall       = !(spm_addr < HALT_BASE);
                  if (spm_addr < HALT_BASE) begin
                     next_st.conc_busy = 1'b1;
                  end
                  next_st.cmd_valid = 1'b1;
                  next_st.cmd_op    = spm_op;
                  next_st.cmd_addr  = spm_addr;
                  next_st.state     = PROG;
                  timer_start       = 1'b1;
               end
            end
         end
         PROG: begin
            // a second store while one runs is dropped, not queued
            if (spm_valid) begin
               next_st.ignored_flag  = 1'b1;
               next_st.ignored_pulse = 1'b1;
            end
            if (timer_done) begin
               next_st.stall   = 1'b0;
               next_st.op_done = 1'b1;
               next_st.state   = IDLE;
            end
         end
         default: begin
            next_st.state = IDLE;
            next_st.stall = 1'b0;
         end
      endcase

      // ---------------- axi4-lite write channels ----------------
      if (s_axi_awvalid && st.awready) begin
         next_st.aw_have = 1'b1;
         next_st.aw_idx  = s_axi_awaddr[3:2];
      end
      if (s_axi_wvalid && st.wready) begin
         next_st.w_have  = 1'b1;
         next_st.w_data  = s_axi_wdata;
         next_st.w_byte0 = s_axi_wstrb[0];
      end
      if (do_write) begin
         next_st.aw_have = 1'b0;
         next_st.w_have  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = RESP_OKAY;
         if (st.aw_idx == LOCK_IDX && st.w_byte0) begin
            next_st.lock = next_st.lock & st.w_data[3:0];
         end
         if (st.aw_idx == BOUND_IDX) begin
            next_st.bresp = RESP_SLVERR; // boundary is read only
         end
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      next_st.awready = !next_st.aw_have && !next_st.bvalid;
      next_st.wready  = !next_st.w_have && !next_st.bvalid;

      // ---------------- axi4-lite read channels ----------------
      if (s_axi_arvalid && st.arready) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = RESP_OKAY;
         next_st.rdata  = 32'h0000_0000;
         case (s_axi_araddr[3:2])
            CTRL_IDX: begin
               next_st.rdata = 32'h0000_0000;
            end
            STATUS_IDX: begin
               next_st.rdata[ST_OP_BUSY_BIT]   = (st.state == PROG);
               next_st.rdata[ST_CONC_BUSY_BIT] = st.conc_busy;
               next_st.rdata[ST_STALL_BIT]     = st.stall;
               next_st.rdata[ST_IGNORED_BIT]   = st.ignored_flag;
               next_st.rdata[ST_DENIED_BIT]    = st.denied_flag;
            end
            LOCK_IDX: begin
               next_st.rdata[3:0] = st.lock;
            end
            BOUND_IDX: begin
               next_st.rdata[ADDR_W-1:0] = st.boot_start;
            end
            default: begin
               next_st.rresp = RESP_SLVERR;
            end
         endcase
      end
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      next_st.arready = !next_st.rvalid;
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st         <= '0;
         st.state   <= IDLE;
         st.lock    <= LOCK_RESET;
         st.cmd_op  <= SPM_LOAD;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------------
   // outputs, all straight from the state register
   // ------------------------------------------------------------------
   assign core_stall              = st.stall;
   assign concurrent_section_busy = st.conc_busy;
   assign flash_cmd_valid         = st.cmd_valid;
   assign flash_cmd_op            = st.cmd_op;
   assign flash_cmd_addr          = st.cmd_addr;
   assign flash_op_done           = st.op_done;
   assign spm_ignored             = st.ignored_pulse;
   assign s_axi_awready           = st.awready;
   assign s_axi_wready            = st.wready;
   assign s_axi_bresp             = st.bresp;
   assign s_axi_bvalid            = st.bvalid;
   assign s_axi_arready           = st.arready;
   assign s_axi_rdata             = st.rdata;
   assign s_axi_rresp             = st.rresp;
   assign s_axi_rvalid            = st.rvalid;

   // timer_running is the timer's own view; state PROG covers it and stays one cycle longer, until done
   logic unused_running;
   assign unused_running = timer_running;

endmodule : self_prog_section_control

//--- self_prog_section_control_test.sv
// testbench for the self-programming section control
// assumes PROG_CYCLES shortened to 8 and a 200 MHz clock
`timescale 1ns/10ps
module self_prog_section_control_test;
   import self_prog_pkg::*;
   localparam int          PC = 8;
   localparam logic [12:0] BS = 13'h1F80; // boot start, fuses 3
   localparam logic [12:0] HA = 13'h1FA4; // page inside boot area
   logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
   logic [1:0]  fuses = 2'h3;
   spm_op_e     c_op = SPM_LOAD, spm_op, cmd_op;
   logic [12:0] c_pc = 13'h0000, c_addr = 13'h0000, spm_pc, spm_addr, cmd_addr;
   logic        spm_valid, core_stall, busy, cmd_v, done, ign;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
   logic        rready = 1'b0, awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [1:0]  bresp, rresp;
   int          failures = 0, total_checks = 0;
   always #2.5 aclk = ~aclk;
   core_model u_core (.aclk, .go, .op(c_op), .pc(c_pc), .addr(c_addr), .spm_op, .spm_valid,
      .spm_pc, .spm_addr);
   self_prog_section_control #(.PROG_CYCLES(PC)) u_dut (.aclk, .aresetn,
      .boot_size_fuses(fuses), .spm_valid, .spm_op, .spm_pc, .spm_addr,
      .spm_lock_data(spm_addr[3:0]), .core_stall, .concurrent_section_busy(busy),
      .flash_cmd_valid(cmd_v), .flash_cmd_op(cmd_op), .flash_cmd_addr(cmd_addr),
      .flash_op_done(done), .spm_ignored(ign), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   // -------------------------------------------------------------
   // shared tasks
   // -------------------------------------------------------------
   task automatic results();
      if (failures == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : results
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic tmo();
      failures++;
      results();
   endtask : tmo
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (n == 50) tmo();
      chk("bresp", bresp, er);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      int n;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (n == 50) tmo();
      d = rdata;
      rready <= 1'b0;
   endtask : rd
   // k: 0 ignored, 1 issued, 2 refused by lock, 3 not judged
   task automatic spm(input spm_op_e o, input logic [12:0] p, a, input int k,
                      input logic st, bz);
      int n;
      @(posedge aclk);
      go <= 1'b1; c_op <= o; c_pc <= p; c_addr <= a;
      @(posedge aclk);
      go <= 1'b0;
      for (n = 0; n < 4; n++) begin
         @(posedge aclk); #1;
         if (cmd_v === 1'b1 || ign === 1'b1) break;
      end
      if (k < 3) chk("cmd", cmd_v, k == 1);
      if (k < 3) chk("ign", ign, k == 0);
      if (k == 1) chk("op", cmd_op, o);
      if (k == 1) chk("addr", cmd_addr, a);
      if (k == 1 && o != SPM_LOAD) begin
         chk("stall", core_stall, st);
         chk("busy", busy, bz);
         for (n = 0; n < 20 && done !== 1'b1; n++) begin @(posedge aclk); #1; end
         if (n == 20) tmo();
         chk("op_time", n, PC + 1);
         chk("stall_end", core_stall, 1'b0);
      end
   endtask : spm
   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic sc_map(input logic [1:0] f);
      logic [31:0] d;
      int          sz;
      sz = 128 << ~f;
      @(posedge aclk);
      fuses <= f; aresetn <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(4'hC, d); chk("bound", d, (8192 - sz < 7168) ? 7168 : 8192 - sz);
      rd(4'h8, d); chk("lock", d, 32'h0000_000F);
      rd(4'h4, d); chk("status", d, 32'h0000_0000);
   endtask : sc_map
   task automatic sc_app();
      logic [31:0] d;
      spm(SPM_ERASE, 13'h0064, 13'h0000, 0, 1'b0, 1'b0);
      rd(4'h4, d); chk("ignored", d, 32'h0000_0008);
      wr(4'h4, 32'h0000_0008, RESP_OKAY);
      rd(4'h4, d); chk("ign_clr", d, 32'h0000_0000);
   endtask : sc_app
   task automatic sc_conc();
      logic [31:0] d;
      spm(SPM_ERASE, BS, 13'h0000, 1, 1'b0, 1'b1);
      spm(SPM_WRITE, BS, 13'h0040, 1, 1'b0, 1'b1);
      rd(4'h4, d); chk("busy_held", d, 32'h0000_0002);
      wr(4'h0, 32'h0000_0001, RESP_OKAY);
      @(posedge aclk); #1;
      chk("busy_ctrl", busy, 1'b0);
      spm(SPM_ERASE, BS, 13'h1BFF, 1, 1'b0, 1'b1);
      spm(SPM_LOAD, BS, 13'h0000, 3, 1'b0, 1'b0);
      chk("busy_load", busy, 1'b0);
   endtask : sc_conc
   task automatic sc_halt();
      spm(SPM_ERASE, BS, HA, 1, 1'b1, 1'b0);
      spm(SPM_WRITE, BS, 13'h1C00, 1, 1'b1, 1'b0);
      spm(SPM_LOCK, BS, 13'h000D, 1, 1'b1, 1'b0);
   endtask : sc_halt
   task automatic sc_protect();
      logic [31:0] d;
      wr(4'h8, 32'h0000_000E, RESP_OKAY);
      spm(SPM_ERASE, BS, 13'h0000, 2, 1'b0, 1'b0);
      rd(4'h4, d); chk("denied", d, 32'h0000_0010);
      wr(4'h4, 32'h0000_0010, RESP_OKAY);
      wr(4'h8, 32'h0000_000B, RESP_OKAY);
      rd(4'h8, d); chk("lock_and", d, 32'h0000_0008);
      spm(SPM_WRITE, BS, HA, 2, 1'b0, 1'b0);
      wr(4'hC, 32'h0000_0000, RESP_SLVERR);
      rd(4'hC, d); chk("bound_ro", d, 32'h0000_1F80);
   endtask : sc_protect
   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      sc_map(2'h0);
      sc_map(2'h3);
      sc_app();
      sc_conc();
      sc_halt();
      sc_protect();
      results();
   end
endmodule : self_prog_section_control_test

//--- self_prog_sva.sv
// checker for the self-programming section control ports
// assumes one clock domain; attached by the bind at the foot of this file
`timescale 1ns/10ps
module self_prog_sva
   import self_prog_pkg::*;
#(
   parameter int ADDR_W      = 13,
   parameter int HALT_START  = 7168,
   parameter int PROG_CYCLES = 8
) (
   // clock and reset
   input wire logic              aclk,
   input wire logic              aresetn,
   // store requests
   input wire logic              spm_valid,
   input wire logic [ADDR_W-1:0] spm_pc,
   // status towards core and flash
   input wire logic              core_stall,
   input wire logic              concurrent_section_busy,
   input wire logic              flash_cmd_valid,
   input wire spm_op_e           flash_cmd_op,
   input wire logic [ADDR_W-1:0] flash_cmd_addr,
   input wire logic              flash_op_done,
   input wire logic              spm_ignored,
   // register bus
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic [1:0]        s_axi_bresp
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [3:0] since_cause;
   logic       prog_op;
   // -------------------------------------------------------------
   // helper logic
   // -------------------------------------------------------------
   // cycles since a bus write or store; a busy drop needs a recent cause
   always_ff @(posedge aclk) begin
      if (!aresetn || s_axi_wvalid || spm_valid) since_cause <= 4'h0;
      else if (since_cause != 4'hF) since_cause <= since_cause + 4'h1;
   end
   assign prog_op = flash_cmd_valid && flash_cmd_op inside {SPM_ERASE, SPM_WRITE};
   // stall spans the whole timed operation, then ends with done
   sequence stall_run;
      core_stall [*8] ##1 core_stall ##1 (!core_stall && flash_op_done);
   endsequence
   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   a_app_store_ignored: assert property (spm_valid && spm_pc < HALT_START |=>
      spm_ignored && !flash_cmd_valid) else $error("application store not ignored");
   a_ignore_no_cmd: assert property (spm_ignored |-> !flash_cmd_valid)
      else $error("ignored store issued a command");
   a_concurrent_runs: assert property (prog_op && flash_cmd_addr < HALT_START |->
      concurrent_section_busy && !core_stall) else $error("concurrent target stalled");
   a_halting_stalls: assert property (prog_op && flash_cmd_addr >= HALT_START |->
      core_stall) else $error("halting target did not stall");
   a_op_duration: assert property (flash_cmd_valid && flash_cmd_op != SPM_LOAD |->
      ##(PROG_CYCLES+1) flash_op_done) else $error("operation time wrong");
   a_stall_span: assert property ($rose(core_stall) |-> stall_run)
      else $error("stall span wrong");
   a_busy_holds: assert property ($fell(concurrent_section_busy) |->
      since_cause < 4'h6) else $error("busy dropped without cause");
   a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
endmodule : self_prog_sva

bind self_prog_section_control self_prog_sva #(.ADDR_W(ADDR_W), .HALT_START(HALT_START),
   .PROG_CYCLES(PROG_CYCLES)) u_sva (.aclk, .aresetn, .spm_valid, .spm_pc, .core_stall,
   .concurrent_section_busy, .flash_cmd_valid, .flash_cmd_op, .flash_cmd_addr,
   .flash_op_done, .spm_ignored, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp);
